// >>> hw/seq_select_cfg.svh
// Constants for the channel-sequence select block
`ifndef SEQ_SELECT_CFG_SVH
`define SEQ_SELECT_CFG_SVH
`define NUM_CHANNELS      4
`define CODE_WIDTH        14
`define PICK_RESET        4'h0
`define CODE_MAX          14'h1fff
`define CODE_MIN          14'h2000
`define CONV_TIME_NS      1650
`define CLK_PERIOD_NS     8
`define CONV_CYCLES       ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EOC_LOW_CYCLES    4
`endif

// >>> hw/seq_select_pkg.sv
// Types shared by the channel-sequence select block
package seq_select_pkg;
   typedef logic [3:0] chan_set_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_EOC  = 3'b100
   } seq_state_t;
endpackage

// >>> hw/sync_2ff.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// >>> hw/adc_channel_sequence_select.sv
// Channel pick, sequence capture, ordering and result coding
`include "seq_select_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_channel_sequence_select (
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic                     conversion_start_n,
   input  wire logic                     source_select,
   input  wire logic [3:0]               hw_channel_pick,
   input  wire logic                     chip_select_n,
   input  wire logic                     write_n,
   input  wire logic                     read_n,
   input  wire logic [13:0]              data_line_in,
   output logic      [13:0]              data_line_out,
   output logic                          data_line_oe,
   input  wire logic [`CODE_WIDTH*`NUM_CHANNELS-1:0] sample_code,
   output logic                          busy,
   output logic                          end_of_conversion_n,
   output logic      [1:0]               conv_channel,
   output logic      [`CODE_WIDTH-1:0]   result_code,
   output logic                          result_valid
);
   // ************************************************************
   // Pin synchronisation
   // ************************************************************
   // Start goes through inverted so that its idle level matches the
   // flops' reset value; a plain copy would show a false start edge
   // two cycles after reset
   logic [8:0] pins_s;
   sync_2ff #(.W(9)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({~conversion_start_n, source_select, hw_channel_pick,
              chip_select_n, write_n, read_n}),
      .q    (pins_s)
   );
   wire        cstart_s = !pins_s[8];
   wire        srcsel_s = pins_s[7];
   wire [3:0]  hwpick_s = pins_s[6:3];
   wire        cs_n_s   = pins_s[2];
   wire        wr_n_s   = pins_s[1];
   wire        rd_n_s   = pins_s[0];

   // Data lines pass two stages like the strobes, so the stored bits
   // are the ones that stood on the first synced sample with the window closed
   logic [3:0] data_low_d1_reg;
   logic [3:0] data_low_d2_reg;

   // ************************************************************
   // Channel pick register
   // ************************************************************
   seq_select_pkg::chan_set_t channel_pick_register;
   logic                      wr_active_reg;
   logic                      cstart_d_reg;
   // A write lands when the synced window closes, i.e. on the strobe's
   // rising edge; the data taps trail the pins by the same two stages
   wire  wr_window   = !cs_n_s && !wr_n_s && rd_n_s;
   wire  wr_rise     = wr_active_reg && !wr_window;
   wire  start_rise  = cstart_s && !cstart_d_reg;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         data_low_d1_reg <= 4'h0;
         data_low_d2_reg <= 4'h0;
      end else begin
         data_low_d1_reg <= data_line_in[3:0];
         data_low_d2_reg <= data_low_d1_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_active_reg         <= 1'b0;
         channel_pick_register <= `PICK_RESET;
         cstart_d_reg          <= 1'b1;
      end else begin
         wr_active_reg <= wr_window;
         cstart_d_reg  <= cstart_s;
         if (wr_rise)
            channel_pick_register <= data_low_d2_reg;
      end
   end

   // Lines are never driven: reads of results are outside this block
   assign data_line_out = 14'h0000;
   assign data_line_oe  = 1'b0;

   // ************************************************************
   // Sequence capture and ordering
   // ************************************************************
   wire [3:0] mux_set = srcsel_s ? channel_pick_register
                                 : hwpick_s;

   function automatic logic [2:0] next_chan(input logic [3:0] set,
                                            input logic [2:0] from);
      logic [2:0] r;
      r = 3'h4;
      for (int i = 3; i >= 0; i--)
         if (set[i] && (3'(i) >= from))
            r = 3'(i);
      return r;
   endfunction

   seq_select_pkg::seq_state_t state_reg;
   seq_select_pkg::seq_state_t state_next;
   seq_select_pkg::chan_set_t  held_set_reg;
   logic [2:0]                 chan_reg;
   logic [2:0]                 chan_next;
   logic [11:0]                cnt_reg;
   logic [11:0]                cnt_next;

   wire [2:0] first_chan = next_chan(mux_set, 3'h0);
   wire [2:0] after_chan = next_chan(held_set_reg, chan_reg + 3'h1);
   wire       conv_done  = (cnt_reg == 12'h000);
   wire       seq_idle   = (state_reg == seq_select_pkg::ST_IDLE);
   wire       seq_conv   = (state_reg == seq_select_pkg::ST_CONV);
   wire       start_take = seq_idle && start_rise;

   always_comb begin
      state_next = state_reg;
      chan_next  = chan_reg;
      cnt_next   = (cnt_reg == 12'h000) ? 12'h000 : cnt_reg - 12'h001;
      case (state_reg)
         seq_select_pkg::ST_IDLE: begin
            if (start_rise && first_chan != 3'h4) begin
               state_next = seq_select_pkg::ST_CONV;
               chan_next  = first_chan;
               cnt_next   = 12'(`CONV_CYCLES - 1);
            end
         end
         seq_select_pkg::ST_CONV: begin
            if (conv_done) begin
               state_next = seq_select_pkg::ST_EOC;
               cnt_next   = 12'(`EOC_LOW_CYCLES - 1);
            end
         end
         seq_select_pkg::ST_EOC: begin
            if (conv_done) begin
               if (after_chan == 3'h4) begin
                  state_next = seq_select_pkg::ST_IDLE;
               end else begin
                  state_next = seq_select_pkg::ST_CONV;
                  chan_next  = after_chan;
                  cnt_next   = 12'(`CONV_CYCLES - 1);
               end
            end
         end
         default: begin
            state_next = seq_select_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg    <= seq_select_pkg::ST_IDLE;
         chan_reg     <= 3'h0;
         cnt_reg      <= 12'h000;
         held_set_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         chan_reg  <= chan_next;
         cnt_reg   <= cnt_next;
         if (start_take)
            held_set_reg <= mux_set;
      end
   end

   // ************************************************************
   // Status outputs
   // ************************************************************
   // Busy and end-of-conversion follow the next state, so both move on
   // the same edge as the state register, with no extra cycle of lag
   wire result_take = seq_conv && conv_done;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy                <= 1'b0;
         end_of_conversion_n <= 1'b1;
         conv_channel        <= 2'h0;
      end else begin
         busy <= (state_next != seq_select_pkg::ST_IDLE);
         end_of_conversion_n <=
            (state_next != seq_select_pkg::ST_EOC);
         conv_channel <= chan_next[1:0];
      end
   end

   // ************************************************************
   // Result coding
   // ************************************************************
   // Code is passed as signed two's complement, untouched; the width
   // is fixed, so no code outside the signed range can appear
   wire [`CODE_WIDTH-1:0] sel_code =
      sample_code[chan_reg[1:0]*`CODE_WIDTH +: `CODE_WIDTH];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         result_code  <= 14'h0000;
         result_valid <= 1'b0;
      end else begin
         result_valid <= result_take;
         if (result_take)
            result_code <= sel_code;
      end
   end
endmodule
`default_nettype wire

// >>> tb/seq_select_properties.sv
// Timing checker for the sequence select block
`timescale 1ns/1ps
`default_nettype none
module seq_select_props (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        conversion_start_n,
   input wire logic        busy,
   input wire logic        end_of_conversion_n,
   input wire logic        result_valid,
   input wire logic [13:0] result_code,
   input wire logic [1:0]  conv_channel,
   input wire logic [55:0] sample_code,
   input wire logic        data_line_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   busy_start_a: assert property ($rose(busy) |->
      $past(conversion_start_n, 3) && !$past(conversion_start_n, 4))
      else $error("busy without start");
   eoc_width_a: assert property ($fell(end_of_conversion_n) |->
      !end_of_conversion_n [*4] ##1 end_of_conversion_n)
      else $error("eoc width");
   eoc_busy_a: assert property (!end_of_conversion_n |-> busy)
      else $error("eoc outside busy");
   busy_end_a: assert property ($fell(busy) |-> $rose(end_of_conversion_n))
      else $error("busy end");
   valid_eoc_a: assert property (result_valid |-> $fell(end_of_conversion_n))
      else $error("valid without eoc");
   result_code_a: assert property (result_valid |->
      result_code == sample_code[conv_channel*14 +: 14])
      else $error("result code");
   chan_order_a: assert property (
      busy && $past(busy) && $changed(conv_channel)
      |-> conv_channel > $past(conv_channel))
      else $error("order");
   lines_in_a: assert property (!data_line_oe)
      else $error("data lines driven");
   cover property ($rose(busy));
   cover property (result_valid && conv_channel == 2'h3);
   cover property ($fell(busy));
endmodule
bind adc_channel_sequence_select seq_select_props chk_u (
   .clk                 (clk),
   .nrst                (nrst),
   .conversion_start_n  (conversion_start_n),
   .busy                (busy),
   .end_of_conversion_n (end_of_conversion_n),
   .result_valid        (result_valid),
   .result_code         (result_code),
   .conv_channel        (conv_channel),
   .sample_code         (sample_code),
   .data_line_oe        (data_line_oe)
);
`default_nettype wire

// >>> tb/host_model.sv
// Host processor model writing the channel pick register
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic   clk,
   output logic        chip_select_n = 1'b1,
   output logic        write_n = 1'b1,
   output logic        read_n = 1'b1,
   output logic [13:0] data_line_in = 14'h0
);
   // Data held four cycles before the strobe rises so the sync flops see it
   task automatic write_pick(input logic [3:0] pick, input logic [9:0] junk);
      @(posedge clk);
      chip_select_n <= 1'b0;
      write_n <= 1'b0;
      data_line_in <= {junk, pick};
      repeat (4) @(posedge clk);
      write_n <= 1'b1;
      chip_select_n <= 1'b1;
      @(posedge clk);
      data_line_in <= ~{junk, pick};
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the sequence select block
`include "seq_select_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, nrst, conversion_start_n, source_select, busy;
   logic        chip_select_n, write_n, read_n, data_line_oe;
   logic        end_of_conversion_n, result_valid;
   logic [3:0]  hw_channel_pick, pick;
   logic [55:0] sample_code, sc;
   logic [13:0] data_line_in, data_line_out, result_code;
   logic [1:0]  conv_channel;
   logic [7:0]  rnd;
   logic [15:0] exp_q[$];
   logic [3:0]  tbl[3] = '{4'hd, 4'h0, 4'hf};
   int          errors, cmp_count;
   host_model host_u (
      .clk           (clk),
      .chip_select_n (chip_select_n),
      .write_n       (write_n),
      .read_n        (read_n),
      .data_line_in  (data_line_in)
   );
   adc_channel_sequence_select dut_u (
      .clk                 (clk),
      .nrst                (nrst),
      .conversion_start_n  (conversion_start_n),
      .source_select       (source_select),
      .hw_channel_pick     (hw_channel_pick),
      .chip_select_n       (chip_select_n),
      .write_n             (write_n),
      .read_n              (read_n),
      .data_line_in        (data_line_in),
      .data_line_out       (data_line_out),
      .data_line_oe        (data_line_oe),
      .sample_code         (sample_code),
      .busy                (busy),
      .end_of_conversion_n (end_of_conversion_n),
      .conv_channel        (conv_channel),
      .result_code         (result_code),
      .result_valid        (result_valid)
   );
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input string n, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic stop_test;
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (result_valid === 1'b1) begin
         if (exp_q.size() == 0) check("extra", 16'h0, 16'h1);
         else check("result", exp_q.pop_front(),
                    {conv_channel, result_code});
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test();
   end
   initial begin
      nrst = 1'b0;
      conversion_start_n = 1'b1;
      source_select = 1'b0;
      hw_channel_pick = 4'h0;
      sample_code = 56'h0;
      rnd = 8'h24;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rnd = lfsr(rnd);
         pick = (i < 3) ? tbl[i] : rnd[3:0];
         sc = {rnd[5:0], 8'h5a, 14'h3fff, `CODE_MIN, `CODE_MAX};
         @(posedge clk);
         source_select <= i[0];
         hw_channel_pick <= i[0] ? ~pick : pick;
         sample_code <= sc;
         if (i[0]) host_u.write_pick(pick, {rnd, 2'h3});
         repeat (4) @(posedge clk);
         for (int c = 0; c < 4; c++)
            if (pick[c]) exp_q.push_back({c[1:0], sc[c*14 +: 14]});
         conversion_start_n <= 1'b0;
         repeat (2) @(posedge clk);
         conversion_start_n <= 1'b1;
         repeat (8) @(posedge clk);
         check("busy_on", {15'h0, pick != 4'h0}, {15'h0, busy});
         hw_channel_pick <= ~hw_channel_pick;
         if (i[0]) host_u.write_pick(~pick, 10'h0);
         for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clk);
         check("busy_off", 16'h0, {15'h0, busy});
         check("queue", 16'h0, 16'(exp_q.size()));
         check("lines_out", 16'h0, {2'h0, data_line_out});
      end
      stop_test();
   end
endmodule
`default_nettype wire
